// file: dv/mdfp_bridge_model.sv
// Purpose: host and bridge side model
// Assumes: flag pins pulled up by host
// Notes: release_go starts one sleep pass
module mdfp_bridge_model (
  input wire logic ref_clk,
  input wire logic release_go,
  input wire logic fault_flag_out_o,
  input wire logic fault_flag_out_oe,
  input wire logic thermal_flag_out_o,
  input wire logic thermal_flag_out_oe,
  output logic sleep_req,
  output logic ff_pin,
  output logic tf_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // sleep held 5 cycles, past the input synchroniser
  logic [2:0] slp_q = 3'h0;
  always_ff @(posedge ref_clk)
  begin
    slp_q <= release_go ? 3'h5 : slp_q - {2'h0, slp_q != 3'h0};
  end
  assign sleep_req = slp_q != 3'h0;
  assign ff_pin = fault_flag_out_oe ? fault_flag_out_o : 1'b1;
  assign tf_pin = thermal_flag_out_oe ? thermal_flag_out_o : 1'b1;
endmodule : mdfp_bridge_model

// file: dv/mdfp_fault_protect_asserts.sv
// Purpose: port checks for fault protection
// Assumes: srst synchronous, active high
// Notes: latencies follow the two-flop input path
module mdfp_fault_protect_asserts #(
  parameter int unsigned NCH = mdfp_pkg::NUM_CHANNELS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic over_temp_raw,
  input wire logic motor_supply_low_raw,
  input wire logic sleep_req,
  input wire logic [NCH-1:0] channel_enable,
  input wire logic logic_reset,
  input wire logic thermal_trip,
  input wire logic overcurrent_trip,
  input wire logic supply_undervoltage_lock,
  input wire logic fault_flag_out_oe,
  input wire logic thermal_flag_out_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // run length of hot samples
  logic [7:0] hot_q = 8'h00;
  always_ff @(posedge ref_clk)
  begin
    hot_q <= (srst || !over_temp_raw) ? 8'h00 : hot_q + {7'h00, hot_q != 8'hff};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  therm_off_a: assert property (thermal_trip |-> channel_enable == '0)
    else $error("outputs on in thermal trip");
  ovc_off_a: assert property (overcurrent_trip |-> channel_enable == '0)
    else $error("outputs on in overcurrent trip");
  uv_reset_a: assert property (supply_undervoltage_lock |-> !channel_enable && logic_reset)
    else $error("undervoltage lock not forcing off");
  fault_flag_a: assert property (fault_flag_out_oe == (thermal_trip || overcurrent_trip))
    else $error("fault flag mismatch");
  therm_flag_a: assert property (thermal_flag_out_oe == thermal_trip)
    else $error("thermal flag mismatch");
  trip_latch_a: assert property ((!sleep_req && !motor_supply_low_raw)[*6] ##0 thermal_trip
    |=> thermal_trip)
    else $error("thermal trip dropped");
  no_glitch_a: assert property ($rose(thermal_trip) |-> $past(hot_q, 3) >= 8'h64)
    else $error("thermal trip too early");
  trip_due_a: assert property (hot_q == 8'h6e && !supply_undervoltage_lock |-> thermal_trip)
    else $error("thermal trip late");
  cover property ($rose(thermal_trip));
  cover property ($rose(overcurrent_trip));
  cover property ($fell(supply_undervoltage_lock));
endmodule : mdfp_fault_protect_asserts
bind mdfp_fault_protect mdfp_fault_protect_asserts #(.NCH(NCH)) u_chk (.*);

// file: dv/mdfp_fault_protect_bench.sv
// Purpose: self-checking bench for fault protection
// Assumes: 20 MHz ref_clk
// Notes: random pulse lengths, fixed seed
module mdfp_fault_protect_bench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
  logic ref_clk = 1'b0, srst = 1'b1, over_temp_raw = 1'b0, motor_supply_low_raw = 1'b0;
  logic [1:0] over_current_raw = 2'h0, channel_enable;
  logic release_go = 1'b0, sleep_req, logic_reset, thermal_trip, overcurrent_trip;
  logic supply_undervoltage_lock, fault_flag_out_o, fault_flag_out_oe, thermal_flag_out_o;
  logic thermal_flag_out_oe, ff_pin, tf_pin;
  int fails = 0;
  int num_checks = 0;
  always #25 ref_clk = ~ref_clk;
  mdfp_fault_protect u_dut (.*);
  mdfp_bridge_model u_far (.*);
  // ==========
  // helpers
  function automatic logic [3:0] exp_out(input logic th, input logic ov);
    return {((th | ov) ? 2'h0 : 2'h3), ~(th | ov), ~th};
  endfunction : exp_out
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic look(input string n, input logic th, input logic ov);
    @(negedge ref_clk);
    `CHK(n, exp_out(th, ov), {channel_enable, ff_pin, tf_pin})
    `CHK(n, {th, ov}, {thermal_trip, overcurrent_trip})
    `CHK(n, 2'h0, {supply_undervoltage_lock, logic_reset})
    @(posedge ref_clk);
  endtask : look
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic await(input logic w);
    int i;
    for (i = 0; i < 200 && (w ? overcurrent_trip : thermal_trip) !== 1'b1; i++)
      @(negedge ref_clk);
    if (i == 200)
    begin
      fails++;
      end_of_test();
    end
    else
    begin
      @(posedge ref_clk);
    end
  endtask : await
  task automatic clear();
    release_go <= 1'b1;
    cyc(1);
    release_go <= 1'b0;
    cyc(14);
  endtask : clear
  // ==========
  // scenarios
  initial
  begin
    void'($urandom(83));
    cyc(10);
    srst <= 1'b0;
    cyc(8);
    look("idle", 1'b0, 1'b0);
    repeat (6)
    begin
      over_temp_raw <= 1'b1;
      cyc(1 + $urandom % 95);
      over_temp_raw <= 1'b0;
      over_current_raw <= 2'h1 << ($urandom % 2);
      cyc(1 + $urandom % 18);
      over_current_raw <= 2'h0;
      cyc(1);
    end
    // corner: one sample short of the thermal and overcurrent dead bands, twice with a one-cycle gap
    for (int k = 0; k < 2; k++)
    begin
      over_temp_raw <= 1'b1;
      over_current_raw <= 2'h3;
      cyc(19);
      over_current_raw <= 2'h0;
      cyc(80);
      over_temp_raw <= 1'b0;
      cyc(1);
    end
    cyc(6);
    look("pulses", 1'b0, 1'b0);
    $display("pulses done");
    over_temp_raw <= 1'b1;
    await(1'b0);
    look("thermal", 1'b1, 1'b0);
    cyc(10);
    over_temp_raw <= 1'b0;
    cyc(30);
    look("held", 1'b1, 1'b0);
    clear();
    look("released", 1'b0, 1'b0);
    $display("thermal done");
    for (int c = 0; c < 2; c++)
    begin
      over_current_raw <= 2'h1 << c;
      await(1'b1);
      over_current_raw <= 2'h0;
      look("ovc", 1'b0, 1'b1);
      clear();
      look("ovc clear", 1'b0, 1'b0);
    end
    $display("ovc done");
    over_temp_raw <= 1'b1;
    await(1'b0);
    over_temp_raw <= 1'b0;
    motor_supply_low_raw <= 1'b1;
    cyc(30);
    @(negedge ref_clk);
    `CHK("uv", 5'h18, {supply_undervoltage_lock, logic_reset, thermal_trip, channel_enable})
    @(posedge ref_clk);
    motor_supply_low_raw <= 1'b0;
    cyc(8);
    look("uv off", 1'b0, 1'b0);
    $display("uv done");
    end_of_test();
  end
endmodule : mdfp_fault_protect_bench

// file: src/mdfp_deadband.sv
// Purpose: dead-band qualifier for one comparator level
// Assumes: raw input already synchronised
// Notes: qual rises after CYCLES continuous high samples
module mdfp_deadband #(
  parameter int unsigned CNT_W = 8,
  parameter logic [CNT_W-1:0] CYCLES = 8'h0064
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic raw,
  output logic qual
);
  logic [CNT_W-1:0] cnt_q;

  // ==========================================================
  // counter, restarts on any low sample
  always_ff @(posedge ref_clk)
  begin
    if (srst || !raw)
    begin
      cnt_q <= '0;
    end
    else if (cnt_q != CYCLES)
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      qual <= 1'b0;
    end
    else
    begin
      // needs CYCLES in a row, so short glitches never qualify
      qual <= raw && (cnt_q == CYCLES - 1'b1 || cnt_q == CYCLES);
    end
  end
endmodule : mdfp_deadband

// file: src/mdfp_fault_protect.sv
// Purpose: fault protection for a two-channel stepping motor driver
// Assumes: comparator levels asynchronous to ref_clk; srst is power-on reset
// Notes: flags are open drain, oe high pulls the pin low
module mdfp_fault_protect #(
  parameter int unsigned NCH = mdfp_pkg::NUM_CHANNELS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic over_temp_raw,
  input wire logic [NCH-1:0] over_current_raw,
  input wire logic motor_supply_low_raw,
  input wire logic sleep_req,
  output logic [NCH-1:0] channel_enable,
  output logic logic_reset,
  output logic thermal_trip,
  output logic overcurrent_trip,
  output logic supply_undervoltage_lock,
  output logic fault_flag_out_o,
  output logic fault_flag_out_oe,
  output logic thermal_flag_out_o,
  output logic thermal_flag_out_oe
);
  // ==========================================================
  // input synchronisers
  localparam int unsigned NIN = NCH + 3;
  logic [NIN-1:0] meta_q;
  logic [NIN-1:0] sync_q;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= {sleep_req, motor_supply_low_raw, over_current_raw, over_temp_raw};
      sync_q <= meta_q;
    end
  end

  logic temp_s;
  logic [NCH-1:0] ovc_s;
  logic uv_s;
  logic sleep_s;
  assign temp_s = sync_q[0];
  assign ovc_s = sync_q[NCH:1];
  assign uv_s = sync_q[NCH+1];
  assign sleep_s = sync_q[NCH+2];

  // ==========================================================
  // dead-band filters
  logic temp_qual;
  logic [NCH-1:0] ovc_qual;
  logic uv_qual;

  mdfp_deadband #(
    .CNT_W(mdfp_pkg::CNT_W),
    .CYCLES(mdfp_pkg::CNT_W'(mdfp_pkg::THERM_DEADBAND_CYC))
  ) u_temp_db (
    .ref_clk(ref_clk),
    .srst(srst),
    .raw(temp_s),
    .qual(temp_qual)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ovc
      mdfp_deadband #(
        .CNT_W(mdfp_pkg::CNT_W),
        .CYCLES(mdfp_pkg::CNT_W'(mdfp_pkg::OVC_DEADBAND_CYC))
      ) u_ovc_db (
        .ref_clk(ref_clk),
        .srst(srst),
        .raw(ovc_s[g]),
        .qual(ovc_qual[g])
      );
    end
  endgenerate

  mdfp_deadband #(
    .CNT_W(mdfp_pkg::CNT_W),
    .CYCLES(mdfp_pkg::CNT_W'(mdfp_pkg::UV_DEADBAND_CYC))
  ) u_uv_db (
    .ref_clk(ref_clk),
    .srst(srst),
    .raw(uv_s),
    .qual(uv_qual)
  );

  // ==========================================================
  // trip latches
  logic therm_q;
  logic ovc_q;
  logic slept_q;
  logic release_evt;

  // release needs a sleep period followed by return to normal
  assign release_evt = slept_q && !sleep_s;

  always_ff @(posedge ref_clk)
  begin
    if (srst || uv_qual)
    begin
      slept_q <= 1'b0;
    end
    else
    begin
      slept_q <= sleep_s;
    end
  end

  // undervoltage resets the latches too; a fresh trip beats release
  always_ff @(posedge ref_clk)
  begin
    if (srst || uv_qual)
    begin
      therm_q <= 1'b0;
    end
    else if (temp_qual)
    begin
      therm_q <= 1'b1;
    end
    else if (release_evt)
    begin
      therm_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || uv_qual)
    begin
      ovc_q <= 1'b0;
    end
    else if (|ovc_qual)
    begin
      ovc_q <= 1'b1;
    end
    else if (release_evt)
    begin
      ovc_q <= 1'b0;
    end
  end

  // ==========================================================
  // state and outputs, all registered
  mdfp_pkg::mdfp_state_t state_q;
  mdfp_pkg::mdfp_state_t state_d;

  always_comb
  begin
    case ({uv_qual, therm_q | ovc_q})
      2'b00: state_d = mdfp_pkg::MDFP_RUN;
      2'b01: state_d = mdfp_pkg::MDFP_TRIPPED;
      2'b10, 2'b11: state_d = mdfp_pkg::MDFP_UVLOCK;
      default: state_d = mdfp_pkg::MDFP_UVLOCK;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_q <= mdfp_pkg::MDFP_UVLOCK;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      channel_enable <= '0;
      logic_reset <= 1'b1;
      supply_undervoltage_lock <= 1'b1;
    end
    else
    begin
      // every channel off for any fault, never just the faulty one
      channel_enable <= (state_d == mdfp_pkg::MDFP_RUN && !sleep_s) ? '1 : '0;
      // step logic held one edge past the lock, so it restarts clean
      logic_reset <= uv_qual || state_q == mdfp_pkg::MDFP_UVLOCK;
      supply_undervoltage_lock <= uv_qual;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      thermal_trip <= 1'b0;
      overcurrent_trip <= 1'b0;
      fault_flag_out_oe <= 1'b0;
      thermal_flag_out_oe <= 1'b0;
      fault_flag_out_o <= 1'b0;
      thermal_flag_out_o <= 1'b0;
    end
    else
    begin
      thermal_trip <= therm_q;
      overcurrent_trip <= ovc_q;
      fault_flag_out_oe <= therm_q | ovc_q;
      thermal_flag_out_oe <= therm_q;
      fault_flag_out_o <= 1'b0;
      thermal_flag_out_o <= 1'b0;
    end
  end
endmodule : mdfp_fault_protect

// file: src/mdfp_pkg.sv
// Purpose: constants for motor driver fault protection
// Assumes: 20 MHz ref_clk
// Notes: times in ns, cycle counts derived below
package mdfp_pkg;
  // ==========================================================
  // clock and dead-band times
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned THERM_DEADBAND_NS = 5000;
  localparam int unsigned OVC_DEADBAND_NS = 1000;
  localparam int unsigned UV_DEADBAND_NS = 1000;
  // least times round up, at least one cycle
  localparam int unsigned THERM_DEADBAND_CYC =
    (THERM_DEADBAND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OVC_DEADBAND_CYC =
    (OVC_DEADBAND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UV_DEADBAND_CYC =
    (UV_DEADBAND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NUM_CHANNELS = 2;
  localparam int unsigned CNT_W = 8;
  // ==========================================================
  // protection state
  typedef enum logic [1:0]
  {
    MDFP_RUN = 2'b00,
    MDFP_UVLOCK = 2'b01,
    MDFP_TRIPPED = 2'b11
  } mdfp_state_t;
endpackage : mdfp_pkg
